// *** hw/fws_pkg.sv ***
// Package for the flash write-status polling controller.
// Assumes a byte-wide asynchronous flash bus driven from a single 200 MHz clock.
package fws_pkg;
  // ********************************************************************
  // Data bit positions on the low data byte
  // ********************************************************************
  localparam int POLLING_STATUS_POS  = 7;
  localparam int FIRST_TOGGLE_POS    = 6;
  localparam int TIMING_LIMIT_POS    = 5;
  localparam int ERASE_WINDOW_POS    = 3;
  localparam int SECOND_TOGGLE_POS   = 2;

  // ********************************************************************
  // Commands and bus timing
  // ********************************************************************
  localparam logic [7:0] RESET_CMD_DATA = 8'hF0;
  localparam logic [7:0] SECTOR_ERASE_DATA = 8'h30;
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int BUS_ACCESS_NS   = 70;
  localparam int BUS_ACCESS_CYC  = (BUS_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WINDOW_GAP_US   = 50;
  localparam int WINDOW_GAP_CYC  = (WINDOW_GAP_US * 1000000) / CLK_PERIOD_PS;
  localparam int ACC_W           = 8;

  typedef enum logic [1:0] {
    FWS_RES_NONE,
    FWS_RES_DONE,
    FWS_RES_FAIL,
    FWS_RES_ABANDON
  } fws_result_type;
endpackage

// *** hw/fws_bus_cycle.sv ***
// One read or write cycle on the flash bus, held for a fixed access count.
// Assumes read data is stable by the end of the access count.
`timescale 1ns/1ps
`default_nettype none
module fws_bus_cycle
  import fws_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic [7:0]  wdata,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdata,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  input  wire logic [7:0]  dq_in
);
  logic [ACC_W-1:0] count;
  logic             is_write;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      is_write <= 1'b0;
      rdata <= 8'h00;
      dq_out <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        is_write <= write;
        dq_out <= wdata;
        count <= ACC_W'(BUS_ACCESS_CYC);
      end else if (busy) begin
        if (count == ACC_W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
          rdata <= dq_in;
        end
        count <= count - ACC_W'(1);
      end
    end
  end

  // Chip enable drops for the whole access, output enable for a whole read, write enable for all but a write's last cycle, so every status read is a fresh cycle
  assign ce_n  = !busy;
  assign oe_n  = !(busy && !is_write);
  assign we_n  = !(busy && is_write && count > ACC_W'(1));
  assign dq_oe = busy && is_write;
endmodule
`default_nettype wire

// *** hw/fws_poll_ctrl.sv ***
// Host controller that polls a flash for program/erase completion.
// Assumes the flash address lines are owned by this block while polling.
// Functional notes
// (RQ1) Start each check with two consecutive status reads, comparing toggle bits.
// (RQ2) Toggle steady means operation done; next read gives array data.
// (RQ3) Toggling with timing-limit flag high: repeat the toggle check once.
// (RQ4) Still toggling after recheck with flag high: fail, write reset command.
// (RQ5) After leaving polling mid-operation, restart from the first two reads.
// (RQ6) Device raises timing-limit flag when pulse count limit exceeded.
// (RQ7) Programming 0 to 1 halts operation and raises timing-limit flag.
// (RQ8) After any timing-limit failure, issue reset command.
// (RQ9) Erase-timer bit reads 0 in acceptance window, 1 after.
// (RQ10) Each added sector erase restarts the acceptance window.
// (RQ11) Erase-timer check may be skipped if sectors follow within 50 us.
// (RQ12) Erase-timer 1 means only erase suspend accepted.
// (RQ13) Check erase-timer before and after each added sector command.
// (RQ14) Status reads use the program address or an erasing sector address.
// (RQ15) Polling bit shows inverse of programmed data until done.
// (RQ16) First toggle bit toggles on every read while busy.
// (RQ17) Second toggle bit toggles in sectors selected for erasure.
// (RQ18) Ready/busy output low while programming or erasing.
// (RQ19) Erase suspend: suspended sector reads polling 1, steady toggle.
// (RQ20) Active erase: polling 0, toggling, erase-timer 1, busy low.
`timescale 1ns/1ps
`default_nettype none
module fws_poll_ctrl
  import fws_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        poll_start,
  input  wire logic        poll_abort,
  input  wire logic [17:0] status_addr,
  input  wire logic        add_sector,
  input  wire logic [17:0] sector_addr,
  output logic             poll_busy,
  output logic             poll_done,
  output fws_result_type   poll_result,
  output logic             sector_rejected,
  output logic             ready_seen,
  output logic [17:0]      flash_addr,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic [7:0]       low_data_byte_lines_out,
  output logic             low_data_byte_lines_oe,
  input  wire logic [7:0]  low_data_byte_lines_in,
  input  wire logic        ready_busy_output
);
  // ********************************************************************
  // State machine
  // ********************************************************************
  typedef enum logic [3:0] {
    FWS_IDLE, FWS_RD1, FWS_RD2, FWS_RD3, FWS_RD4,
    FWS_RST, FWS_PRE, FWS_ADD, FWS_POST, FWS_FIN
  } fws_state_type;

  fws_state_type state;
  logic          cyc_start;
  logic          cyc_write;
  logic [7:0]    cyc_wdata;
  logic          cyc_busy;
  logic          cyc_done;
  logic [7:0]    cyc_rdata;
  logic          first_toggle;
  logic          rdy_meta;
  logic          rdy_sync;
  logic          issued;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_meta <= 1'b1;
      rdy_sync <= 1'b1;
    end else begin
      rdy_meta <= ready_busy_output;
      rdy_sync <= rdy_meta;
    end
  end
  // Ready/busy pin is open-drain; synchronised level only [RQ18]
  assign ready_seen = rdy_sync;

  wire cyc_go = issued && cyc_done;
  wire toggled = cyc_rdata[FIRST_TOGGLE_POS] != first_toggle;
  wire limit_hi = cyc_rdata[TIMING_LIMIT_POS];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= FWS_IDLE;
      first_toggle <= 1'b0;
      poll_done <= 1'b0;
      poll_result <= FWS_RES_NONE;
      sector_rejected <= 1'b0;
      flash_addr <= '0;
      issued <= 1'b0;
    end else begin
      poll_done <= 1'b0;
      if (cyc_start) issued <= 1'b1;
      else if (cyc_done) issued <= 1'b0;
      case (state)
        FWS_IDLE: begin
          if (poll_start) begin
            flash_addr <= status_addr; // [RQ14]
            state <= FWS_RD1; // Always from the first read [RQ5]
          end else if (add_sector) begin
            flash_addr <= sector_addr;
            sector_rejected <= 1'b0;
            state <= FWS_PRE; // [RQ13]
          end
        end
        FWS_RD1: if (cyc_go) begin
          first_toggle <= cyc_rdata[FIRST_TOGGLE_POS];
          state <= FWS_RD2; // [RQ1]
        end
        FWS_RD2: if (cyc_go) begin
          first_toggle <= cyc_rdata[FIRST_TOGGLE_POS];
          if (!toggled) begin
            poll_result <= FWS_RES_DONE; // [RQ2] [RQ16]
            state <= FWS_FIN;
          end else if (limit_hi) state <= FWS_RD3; // [RQ3] [RQ6] [RQ7]
          else if (poll_abort) begin
            poll_result <= FWS_RES_ABANDON; // [RQ5]
            state <= FWS_FIN;
          end else state <= FWS_RD1;
        end
        FWS_RD3: if (cyc_go) begin
          first_toggle <= cyc_rdata[FIRST_TOGGLE_POS];
          state <= FWS_RD4;
        end
        FWS_RD4: if (cyc_go) begin
          if (!toggled) begin
            poll_result <= FWS_RES_DONE; // [RQ3]
            state <= FWS_FIN;
          end else state <= FWS_RST; // [RQ4]
        end
        FWS_RST: if (cyc_go) begin
          poll_result <= FWS_RES_FAIL; // [RQ8]
          state <= FWS_FIN;
        end
        FWS_PRE: if (cyc_go) begin
          // Window already closed: command would be ignored [RQ12] [RQ9]
          if (cyc_rdata[ERASE_WINDOW_POS]) begin
            sector_rejected <= 1'b1;
            state <= FWS_FIN;
          end else state <= FWS_ADD; // [RQ10]
        end
        FWS_ADD: if (cyc_go) state <= FWS_POST;
        FWS_POST: if (cyc_go) begin
          sector_rejected <= cyc_rdata[ERASE_WINDOW_POS]; // [RQ13]
          state <= FWS_FIN;
        end
        FWS_FIN: begin
          poll_done <= 1'b1;
          state <= FWS_IDLE;
        end
        default: state <= FWS_IDLE;
      endcase
    end
  end

  // Single added sector; multi-sector windows rely on caller pacing [RQ11]
  always_comb begin
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    cyc_wdata = 8'h00;
    if (!cyc_busy && !issued) begin
      case (state)
        FWS_RD1, FWS_RD2, FWS_RD3, FWS_RD4, FWS_PRE, FWS_POST: cyc_start = 1'b1;
        FWS_RST: begin
          cyc_start = 1'b1;
          cyc_write = 1'b1;
          cyc_wdata = RESET_CMD_DATA;
        end
        FWS_ADD: begin
          cyc_start = 1'b1;
          cyc_write = 1'b1;
          cyc_wdata = SECTOR_ERASE_DATA;
        end
        default: cyc_start = 1'b0;
      endcase
    end
  end

  assign poll_busy = state != FWS_IDLE;

  fws_bus_cycle u_cycle (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (cyc_start),
    .write   (cyc_write),
    .wdata   (cyc_wdata),
    .busy    (cyc_busy),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .ce_n    (flash_ce_n),
    .oe_n    (flash_oe_n),
    .we_n    (flash_we_n),
    .dq_out  (low_data_byte_lines_out),
    .dq_oe   (low_data_byte_lines_oe),
    .dq_in   (low_data_byte_lines_in)
  );

  // ********************************************************************
  // Checks
  // ********************************************************************
  chk_fail_writes_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FWS_RD4 && cyc_go && toggled) |=> state == FWS_RST) // [RQ4]
    else $error("fail did not lead to reset write");
  chk_steady_is_done: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FWS_RD2 && cyc_go && !toggled) |=> ##1 (poll_done && poll_result == FWS_RES_DONE)) // [RQ2]
    else $error("steady toggle not reported done");
  chk_limit_rechecks: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FWS_RD2 && cyc_go && toggled && limit_hi) |=> state == FWS_RD3) // [RQ3]
    else $error("timing limit did not trigger recheck");
  chk_start_first_read: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FWS_IDLE && poll_start) |=> state == FWS_RD1) // [RQ1]
    else $error("poll did not start with first read");
  chk_reset_data_out: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FWS_RST && !flash_we_n) |-> low_data_byte_lines_out == RESET_CMD_DATA) // [RQ8]
    else $error("reset command data wrong");
  chk_window_reject: assert property (@(posedge clk) disable iff (sys_rst)
    (state == FWS_PRE && cyc_go && cyc_rdata[ERASE_WINDOW_POS]) |=> sector_rejected) // [RQ12]
    else $error("closed window not flagged");
  chk_abandon_restart: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(poll_done) && poll_result == FWS_RES_ABANDON |=> state == FWS_IDLE) // [RQ5]
    else $error("abandon did not return to idle");
  chk_drive_on_write: assert property (@(posedge clk) disable iff (sys_rst)
    !flash_we_n |-> (low_data_byte_lines_oe && flash_oe_n)) // [RQ13]
    else $error("write strobe without bus drive");
endmodule
`default_nettype wire

// *** dv/fws_flash_model.sv ***
// Behavioural flash that answers status reads and commands.
// Assumes the bench pulses arm before each operation.
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model
  import fws_pkg::*;
(
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [17:0] addr,
  input  wire logic [7:0]  dq_wr,
  output logic      [7:0]  dq_rd,
  output logic             rb,
  input  wire logic        arm,
  input  var  int          busy_reads,
  input  wire logic        lim,
  input  var  int          win_ns
);
  // ****************************************************************
  // Status and commands
  // ****************************************************************
  int          n;
  int          writes;
  logic        got_reset;
  logic [17:0] rd_addr;
  realtime     t_add;
  logic        bsy;
  logic        win_done;
  assign bsy = !got_reset && (n < busy_reads);
  // Ready stays high whenever no operation runs or a reset command was taken
  assign rb  = !bsy;
  initial dq_rd = 8'hA5;
  always @(posedge arm) begin
    n = 0;
    writes = 0;
    got_reset = 0;
    t_add = $realtime;
  end
  always @(negedge oe_n or posedge oe_n) begin
    if (!oe_n && !ce_n) begin
      rd_addr = addr;
      win_done = ($realtime - t_add) > win_ns;
      // Toggle bits flip per read only while busy, steady after
      dq_rd = {!bsy, bsy ? n[0] : busy_reads[0], lim && !got_reset, 1'b0, win_done, bsy & n[0], 2'b00};
    end else if (oe_n) begin
      n = n + 1;
      dq_rd = ~dq_rd; // Released bus must not keep the last value
    end
  end
  always @(posedge we_n) begin
    if (!ce_n) begin
      writes = writes + 1;
      if (dq_wr == RESET_CMD_DATA) got_reset = 1;
      if (dq_wr == SECTOR_ERASE_DATA && ($realtime - t_add) <= win_ns) t_add = $realtime;
    end
  end
endmodule
`default_nettype wire

// *** dv/test_fws_poll_ctrl.sv ***
// Self-checking bench for the polling controller against a flash model.
// Assumes a 200 MHz clock and a reference model of the polling procedure.
`timescale 1ns/1ps
`default_nettype none
module test_fws_poll_ctrl;
  import fws_pkg::*;
  // ****************************************************************
  // Stimulus and checking
  // ****************************************************************
  logic clk = 0, sys_rst = 1, poll_start = 0, poll_abort = 0, add_sector = 0, arm = 0, lim = 0;
  logic [17:0] status_addr = 18'h0, sector_addr = 18'h0, flash_addr;
  logic poll_busy, poll_done, sector_rejected, ready_seen, ce_n, oe_n, we_n, dq_oe, rb;
  fws_result_type poll_result;
  logic [7:0] dq_out, dq_rd;
  logic [31:0] seed = 32'h5D8CE779;
  int busy_reads = 0, win_ns = 0, err_total = 0, cmp_count = 0, cyc = 0, i;
  always #2.5 clk = ~clk;
  fws_poll_ctrl u_fws_poll_ctrl (.clk(clk), .sys_rst(sys_rst), .poll_start(poll_start),
    .poll_abort(poll_abort), .status_addr(status_addr), .add_sector(add_sector),
    .sector_addr(sector_addr), .poll_busy(poll_busy), .poll_done(poll_done),
    .poll_result(poll_result), .sector_rejected(sector_rejected), .ready_seen(ready_seen),
    .flash_addr(flash_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .low_data_byte_lines_out(dq_out), .low_data_byte_lines_oe(dq_oe),
    .low_data_byte_lines_in(dq_oe ? dq_out : dq_rd), .ready_busy_output(rb));
  fws_flash_model u_fws_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(flash_addr),
    .dq_wr(dq_out), .dq_rd(dq_rd), .rb(rb), .arm(arm), .busy_reads(busy_reads), .lim(lim),
    .win_ns(win_ns));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Reference of the polling procedure, two reads per pair
  function automatic int ref_res(input int b, input logic l, input logic ab);
    int n;
    n = 0;
    forever begin
      if (n >= b) return 1;
      if (l) return (n + 2 >= b) ? 1 : 2;
      if (ab) return 3;
      n = n + 2;
    end
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic op(input logic st);
    int k;
    @(posedge clk);
    #1 arm = 1;
    poll_start = st;
    add_sector = !st;
    @(posedge clk);
    #1 arm = 0;
    poll_start = 0;
    add_sector = 0;
    check("poll_busy", 18'h1, {17'h0, poll_busy});
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (!poll_done && k < 5000);
    check("poll_done", 18'h1, {17'h0, poll_done});
  endtask
  task automatic poll(input int b, input logic l, input logic ab);
    int r;
    busy_reads = b;
    lim = l;
    poll_abort = ab;
    status_addr = seed[17:0];
    op(1'b1);
    r = ref_res(b, l, ab);
    check("poll_result", 18'(r), {16'h0, poll_result});
    check("reset_cmd", 18'(r == 2), 18'(u_fws_flash_model.writes));
    check("status_addr", status_addr, u_fws_flash_model.rd_addr);
    // Abandon leaves after two reads, so the flash is still busy unless it needed two or fewer
    check("ready_seen", 18'(r != 3 || b <= 2), {17'h0, ready_seen});
    poll_abort = 0;
  endtask
  task automatic add(input int w, input logic exp, input int nwr);
    win_ns = w;
    busy_reads = 0;
    sector_addr = seed[17:0];
    op(1'b0);
    check("sector_rejected", 18'(exp), {17'h0, sector_rejected});
    check("sector_cmd", 18'(nwr), 18'(u_fws_flash_model.writes));
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 0;
    poll(0, 1'b0, 1'b0);
    poll(1000, 1'b1, 1'b0);
    poll(2, 1'b1, 1'b0);
    poll(1000, 1'b0, 1'b1);
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      poll(int'(seed[2:0]), seed[3], seed[4]);
    end
    add(1000000, 1'b0, 1);
    add(0, 1'b1, 0);
    // Write lands 154 ns after arming and the post read at 169 ns: passes only if the write restarts the window
    add(160, 1'b0, 1);
    // Window closes before the write, so the post check must see the timer set
    add(100, 1'b1, 1);
    check("ready_seen", 18'h1, {17'h0, ready_seen});
    print_verdict();
  end
endmodule
`default_nettype wire
